// File: core/capture_event_mux.sv
`timescale 1ns/100ps
module capture_event_mux
    import cfg_one_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [4:0] eventSelect,
    input wire logic pinEvent,
    input wire logic audioTxEvent,
    input wire logic audioRxEvent,
    input wire logic [ETH_EVENTS-1:0] ethEvents,
    output logic captureEvent,
    output logic selectValid
);
    logic captureEvent_r, captureEvent_nxt;
    logic selectValid_r, selectValid_nxt;
    logic [4:0] ethIndex;

    always_comb begin
        ethIndex = eventSelect - SEL_ETH_CH0;
        captureEvent_nxt = 1'b0;
        selectValid_nxt = 1'b1;
        if (eventSelect == SEL_PIN) begin
            captureEvent_nxt = pinEvent;
        end else if (eventSelect == SEL_AUDIO_TX) begin
            captureEvent_nxt = audioTxEvent;
        end else if (eventSelect == SEL_AUDIO_RX) begin
            captureEvent_nxt = audioRxEvent;
        end else if (eventSelect >= SEL_ETH_CH0 && eventSelect <= SEL_ETH_LAST) begin
            // Channel is index/4, event kind is index%4.
            captureEvent_nxt = ethEvents[ethIndex[3:0]];
        end else begin
            // Reserved codes hold the capture input quiet.
            selectValid_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            captureEvent_r <= 1'b0;
            selectValid_r <= 1'b1;
        end else begin
            captureEvent_r <= captureEvent_nxt;
            selectValid_r <= selectValid_nxt;
        end
    end

    assign captureEvent = captureEvent_r;
    assign selectValid = selectValid_r;

    ////////////////////////////////////////////////////////////////////////////
    chk_eth_ch0: assert property (@(posedge sys_clk) disable iff (reset)
        eventSelect == SEL_ETH_CH0_LAST |=> captureEvent == $past(ethEvents[3]))
        else $error("channel 0 miscellaneous event misrouted");
    chk_eth_ch1: assert property (@(posedge sys_clk) disable iff (reset)
        eventSelect == SEL_ETH_CH1 |=> captureEvent == $past(ethEvents[4]))
        else $error("channel 1 threshold event misrouted");
    chk_eth_ch2: assert property (@(posedge sys_clk) disable iff (reset)
        eventSelect == SEL_ETH_LAST |=> captureEvent == $past(ethEvents[11]))
        else $error("channel 2 miscellaneous event misrouted");
    chk_reserved_quiet: assert property (@(posedge sys_clk) disable iff (reset)
        (eventSelect > SEL_ETH_LAST || (eventSelect > SEL_AUDIO_RX && eventSelect < SEL_ETH_CH0))
        |=> !captureEvent && !selectValid)
        else $error("reserved code let an event through");

endmodule // capture_event_mux

// File: core/capture_source_host_port_cfg.sv
// How it works
// - Bits 31-27 select capture unit 2 source.
// - Bits 26-22 select capture unit 1 source.
// - Bits 21-17 select capture unit 0 source.
// - Codes 7h-Ah route ethernet channel 0 events.
// - Codes Bh-Eh route ethernet channel 1 events.
// - Codes Fh-12h route ethernet channel 2 events.
// - Bit 16 picks byte or word host addressing.
// - Bit 15 enables host port and its pins.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
module capture_source_host_port_cfg #(
    parameter int HOST_ADDR_W = 16,
    parameter int HOST_PIN_W = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [cfg_one_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [cfg_one_pkg::DATA_W-1:0] writedata,
    input wire logic [cfg_one_pkg::BE_W-1:0] byteenable,
    output logic [cfg_one_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic [cfg_one_pkg::CAP_UNITS-1:0] capturePin,
    input wire logic audioTxDmaEvent,
    input wire logic audioRxDmaEvent,
    input wire logic [cfg_one_pkg::ETH_EVENTS-1:0] ethEvents,
    output logic [cfg_one_pkg::CAP_UNITS-1:0] captureEvent,
    output logic [cfg_one_pkg::LOWER_W-1:0] lowerConfigBits,
    output logic host_port_byte_addressing,
    output logic host_port_enable,
    input wire logic [HOST_ADDR_W-1:0] hostAddress,
    output logic [HOST_ADDR_W-1:0] hostByteAddress,
    input wire logic [HOST_PIN_W-1:0] hostPinOut,
    input wire logic [HOST_PIN_W-1:0] hostPinOe,
    input wire logic [HOST_PIN_W-1:0] sharedPinOut,
    input wire logic [HOST_PIN_W-1:0] sharedPinOe,
    output logic [HOST_PIN_W-1:0] pinOut,
    output logic [HOST_PIN_W-1:0] pinOe
);
    import cfg_one_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state.
    bus_state_t busState_r, busState_nxt;
    logic [DATA_W-1:0] readdata_r, readdata_nxt;
    logic [DATA_W-1:0] cfgOne_r, cfgOne_nxt;
    logic [DATA_W-1:0] byteMask;
    logic [DATA_W-1:0] statusWord;
    logic [CAP_UNITS-1:0] selectValid;
    logic requestActive;

    assign requestActive = read | write;

    // Every access waits exactly one cycle, which lets read data come from a
    // flip-flop without a combinational path from the address.
    always_comb begin
        busState_nxt = busState_r;
        case (busState_r)
            BUS_IDLE: begin
                if (requestActive) begin
                    busState_nxt = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                busState_nxt = BUS_IDLE;
            end
            default: begin
                busState_nxt = BUS_IDLE;
            end
        endcase
    end

    assign waitrequest = requestActive & (busState_r != BUS_ANSWER);

    always_comb begin
        for (int b = 0; b < BE_W; b++) begin
            byteMask[b*8 +: 8] = {8{byteenable[b]}};
        end
    end

    always_comb begin
        statusWord = '0;
        statusWord[STAT_EVENT_LSB +: CAP_UNITS] = captureEvent;
        statusWord[STAT_VALID_LSB +: CAP_UNITS] = selectValid;
    end

    // The write lands at the edge where waitrequest is low; unmapped
    // addresses read zero and swallow writes.
    always_comb begin
        cfgOne_nxt = cfgOne_r;
        readdata_nxt = readdata_r;
        if (busState_r == BUS_ANSWER && write && address == CFG_ONE_OFFSET) begin
            cfgOne_nxt = (cfgOne_r & ~(byteMask & CFG_ONE_WMASK))
                | (writedata & byteMask & CFG_ONE_WMASK);
        end
        if (busState_r == BUS_IDLE && read) begin
            case (address)
                CFG_ONE_OFFSET: begin
                    readdata_nxt = cfgOne_r;
                end
                STATUS_OFFSET: begin
                    readdata_nxt = statusWord;
                end
                default: begin
                    readdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            busState_r <= BUS_IDLE;
            readdata_r <= '0;
            cfgOne_r <= CFG_ONE_RESET;
        end else begin
            busState_r <= busState_nxt;
            readdata_r <= readdata_nxt;
            cfgOne_r <= cfgOne_nxt;
        end
    end

    assign readdata = readdata_r;
    assign lowerConfigBits = cfgOne_r[LOWER_W-1:0];
    assign host_port_byte_addressing = cfgOne_r[HP_BYTE_BIT];
    assign host_port_enable = cfgOne_r[HP_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Capture event routing, one selector per unit, five bits apart.
    for (genvar i = 0; i < CAP_UNITS; i++) begin : g_cap
        capture_event_mux u_mux (
            .sys_clk(sys_clk),
            .reset(reset),
            .eventSelect(cfgOne_r[CAP0_LSB + i*SEL_W +: SEL_W]),
            .pinEvent(capturePin[i]),
            .audioTxEvent(audioTxDmaEvent),
            .audioRxEvent(audioRxDmaEvent),
            .ethEvents(ethEvents),
            .captureEvent(captureEvent[i]),
            .selectValid(selectValid[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host port address and pin ownership.
    logic [HOST_ADDR_W-1:0] hostByteAddress_r, hostByteAddress_nxt;
    logic [HOST_PIN_W-1:0] pinOut_r, pinOut_nxt;
    logic [HOST_PIN_W-1:0] pinOe_r, pinOe_nxt;

    always_comb begin
        // Word addresses are scaled to bytes; top bits are lost by design.
        if (host_port_byte_addressing) begin
            hostByteAddress_nxt = hostAddress;
        end else begin
            hostByteAddress_nxt = {hostAddress[HOST_ADDR_W-3:0], 2'b00};
        end
        if (host_port_enable) begin
            pinOut_nxt = hostPinOut;
            pinOe_nxt = hostPinOe;
        end else begin
            pinOut_nxt = sharedPinOut;
            pinOe_nxt = sharedPinOe;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hostByteAddress_r <= '0;
            pinOut_r <= '0;
            pinOe_r <= '0;
        end else begin
            hostByteAddress_r <= hostByteAddress_nxt;
            pinOut_r <= pinOut_nxt;
            pinOe_r <= pinOe_nxt;
        end
    end

    assign hostByteAddress = hostByteAddress_r;
    assign pinOut = pinOut_r;
    assign pinOe = pinOe_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence fullCfgWrite;
        busState_r == BUS_IDLE && write && address == CFG_ONE_OFFSET && byteenable == 4'hF;
    endsequence

    chk_cap2_field: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP2_LSB +: SEL_W] == SEL_PIN |=> captureEvent[2] == $past(capturePin[2]))
        else $error("capture unit 2 pin route wrong");
    chk_cap1_field: assert property (@(posedge sys_clk) disable iff (reset)
        fullCfgWrite |-> ##2 cfgOne_r[CAP1_LSB +: SEL_W] == $past(writedata[26:22], 2))
        else $error("capture unit 1 selector not stored");
    chk_cap0_audio: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP0_LSB +: SEL_W] == SEL_AUDIO_RX
        |=> captureEvent[0] == $past(audioRxDmaEvent))
        else $error("capture unit 0 audio receive route wrong");
    chk_eth_route: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP1_LSB +: SEL_W] == SEL_ETH_CH0 |=> captureEvent[1] == $past(ethEvents[0]))
        else $error("channel 0 threshold pulse misrouted");
    chk_host_word: assert property (@(posedge sys_clk) disable iff (reset)
        !cfgOne_r[HP_BYTE_BIT]
        |=> hostByteAddress == {$past(hostAddress[HOST_ADDR_W-3:0]), 2'b00})
        else $error("word address not scaled");
    chk_host_pins: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[HP_EN_BIT] |=> pinOe == $past(hostPinOe) && pinOut == $past(hostPinOut))
        else $error("host port does not own its pins");
    chk_host_release: assert property (@(posedge sys_clk) disable iff (reset)
        !cfgOne_r[HP_EN_BIT] |=> pinOe == $past(sharedPinOe))
        else $error("disabled host port still drives pins");
    chk_bus_answer: assert property (@(posedge sys_clk) disable iff (reset)
        busState_r == BUS_IDLE && requestActive |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not after one wait cycle");
    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[11:4] == 8'h00)
        else $error("reserved bits changed");

    // Bus timing: a write changes nothing at the request edge and lands one edge later; read data is loaded at the request edge.
    chk_write_early: assert property (@(posedge sys_clk) disable iff (reset)
        busState_r == BUS_IDLE && write |=> cfgOne_r == $past(cfgOne_r))
        else $error("write landed while waitrequest was high");
    chk_write_stored: assert property (@(posedge sys_clk) disable iff (reset)
        busState_r == BUS_ANSWER && write && address == CFG_ONE_OFFSET && byteenable == 4'hF
        |=> cfgOne_r == ($past(writedata) & CFG_ONE_WMASK))
        else $error("full write not stored");
    chk_read_config: assert property (@(posedge sys_clk) disable iff (reset)
        busState_r == BUS_IDLE && read && address == CFG_ONE_OFFSET
        |=> readdata == $past(cfgOne_r))
        else $error("config read returned wrong word");
    chk_read_unmapped: assert property (@(posedge sys_clk) disable iff (reset)
        busState_r == BUS_IDLE && read && address != CFG_ONE_OFFSET && address != STATUS_OFFSET
        |=> readdata == '0)
        else $error("unmapped read not zero");
    chk_status_word: assert property (@(posedge sys_clk) disable iff (reset)
        busState_r == BUS_IDLE && read && address == STATUS_OFFSET
        |=> readdata[STAT_VALID_LSB +: CAP_UNITS] == $past(selectValid)
            && readdata[STAT_EVENT_LSB +: CAP_UNITS] == $past(captureEvent))
        else $error("status word wrong");
    chk_idle_bus: assert property (@(posedge sys_clk) disable iff (reset)
        !requestActive |-> !waitrequest)
        else $error("waitrequest high with no request");

    // Each selector steers its own unit, one edge behind the chosen source.
    chk_cap2_audio: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP2_LSB +: SEL_W] == SEL_AUDIO_TX |=> captureEvent[2] == $past(audioTxDmaEvent))
        else $error("capture unit 2 audio transmit route wrong");
    chk_cap1_pin: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP1_LSB +: SEL_W] == SEL_PIN |=> captureEvent[1] == $past(capturePin[1]))
        else $error("capture unit 1 pin route wrong");
    chk_cap0_pin: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP0_LSB +: SEL_W] == SEL_PIN |=> captureEvent[0] == $past(capturePin[0]))
        else $error("capture unit 0 pin route wrong");
    chk_cap2_eth: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP2_LSB +: SEL_W] == SEL_ETH_CH1_LAST |=> captureEvent[2] == $past(ethEvents[7]))
        else $error("channel 1 miscellaneous event misrouted");
    chk_cap0_eth: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP0_LSB +: SEL_W] == SEL_ETH_CH2 |=> captureEvent[0] == $past(ethEvents[8]))
        else $error("channel 2 threshold pulse misrouted");
    chk_reserved_status: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP1_LSB +: SEL_W] > SEL_ETH_LAST |=> !selectValid[1] && !captureEvent[1])
        else $error("reserved code not flagged");

    // Host port side.
    chk_host_byte: assert property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[HP_BYTE_BIT] |=> hostByteAddress == $past(hostAddress))
        else $error("byte address altered");
    chk_shared_out: assert property (@(posedge sys_clk) disable iff (reset)
        !cfgOne_r[HP_EN_BIT] |=> pinOut == $past(sharedPinOut))
        else $error("disabled host port still owns pin data");

    cov_eth_route: cover property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP2_LSB +: SEL_W] == SEL_ETH_CH2 ##1 captureEvent[2]);
    cov_host_on: cover property (@(posedge sys_clk) disable iff (reset)
        !host_port_enable ##1 host_port_enable);
    cov_byte_mode: cover property (@(posedge sys_clk) disable iff (reset)
        host_port_byte_addressing && host_port_enable);
    cov_status_read: cover property (@(posedge sys_clk) disable iff (reset)
        read && address == STATUS_OFFSET && !waitrequest);
    cov_reserved_code: cover property (@(posedge sys_clk) disable iff (reset)
        cfgOne_r[CAP0_LSB +: SEL_W] > SEL_ETH_LAST ##1 !selectValid[0]);

endmodule // capture_source_host_port_cfg

// File: core/cfg_one_pkg.sv
package cfg_one_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry and register map.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam logic [3:0] CFG_ONE_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout of chip_config_one.
    localparam int SEL_W = 5;
    localparam int CAP_UNITS = 3;
    localparam int CAP0_LSB = 17;
    localparam int CAP1_LSB = 22;
    localparam int CAP2_LSB = 27;
    localparam int HP_BYTE_BIT = 16;
    localparam int HP_EN_BIT = 15;
    localparam int LOWER_W = 15;
    localparam logic [31:0] CFG_ONE_RESET = 32'h0000_0000;
    // Bits 11 to 4 are reserved; they keep their default and read as zero.
    localparam logic [31:0] CFG_ONE_WMASK = 32'hFFFF_F00F;

    ////////////////////////////////////////////////////////////////////////////
    // Status register layout.
    localparam int STAT_EVENT_LSB = 0;
    localparam int STAT_VALID_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Capture selector codes.
    localparam logic [4:0] SEL_PIN = 5'h00;
    localparam logic [4:0] SEL_AUDIO_TX = 5'h01;
    localparam logic [4:0] SEL_AUDIO_RX = 5'h02;
    localparam logic [4:0] SEL_ETH_CH0 = 5'h07;
    localparam logic [4:0] SEL_ETH_CH0_LAST = 5'h0A;
    localparam logic [4:0] SEL_ETH_CH1 = 5'h0B;
    localparam logic [4:0] SEL_ETH_CH1_LAST = 5'h0E;
    localparam logic [4:0] SEL_ETH_CH2 = 5'h0F;
    localparam logic [4:0] SEL_ETH_LAST = 5'h12;
    localparam int ETH_EVENTS = 12;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;

endpackage

// File: verif/capture_source_host_port_cfg_test.sv
`timescale 1ns/100ps
module capture_source_host_port_cfg_test;
    import cfg_one_pkg::*;
    logic sysClk = 1'b0;
    logic reset = 1'b1;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest, audioTx, audioRx, byteMode, hostEn;
    logic [2:0] capturePin, captureEvent;
    logic [11:0] ethEvents;
    logic [14:0] lowerBits;
    logic [15:0] hostAddress, hostByteAddress;
    logic [7:0] hostPinOut, hostPinOe, sharedPinOut, sharedPinOe, pinOut, pinOe;
    logic [31:0] cfgModel = 32'h0000_0000;
    int nFail = 0;
    int nCompared = 0;

    always #12.5 sysClk = ~sysClk;

    event_source_model event_source_model_inst (.sys_clk(sysClk), .reset(reset),
        .capturePin(capturePin), .audioTxEvent(audioTx), .audioRxEvent(audioRx),
        .ethEvents(ethEvents), .hostAddress(hostAddress), .hostPinOut(hostPinOut),
        .hostPinOe(hostPinOe), .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe));

    capture_source_host_port_cfg capture_source_host_port_cfg_inst (.sys_clk(sysClk),
        .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .capturePin(capturePin), .audioTxDmaEvent(audioTx), .audioRxDmaEvent(audioRx),
        .ethEvents(ethEvents), .captureEvent(captureEvent), .lowerConfigBits(lowerBits),
        .host_port_byte_addressing(byteMode), .host_port_enable(hostEn),
        .hostAddress(hostAddress), .hostByteAddress(hostByteAddress),
        .hostPinOut(hostPinOut), .hostPinOe(hostPinOe), .sharedPinOut(sharedPinOut),
        .sharedPinOe(sharedPinOe), .pinOut(pinOut), .pinOe(pinOe));

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] expected);
        nCompared++;
        if (seen !== expected) begin
            nFail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task access(input logic wr, input logic [3:0] addr, input logic [31:0] data,
                input logic [3:0] be, output logic [31:0] rdata);
        @(posedge sysClk);
        read <= !wr;
        write <= wr;
        address <= addr;
        writedata <= data;
        byteenable <= be;
        do @(posedge sysClk); while (waitrequest !== 1'b0);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task wr(input logic [3:0] addr, input logic [31:0] data, input logic [3:0] be);
        logic [31:0] m, d;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & CFG_ONE_WMASK;
        access(1'b1, addr, data, be, d);
        if (addr == CFG_ONE_OFFSET) cfgModel = (cfgModel & ~m) | (data & m);
        repeat (2) @(posedge sysClk);
    endtask

    task rd(input logic [3:0] addr, input logic [31:0] expected);
        logic [31:0] d;
        access(1'b0, addr, 32'h0000_0000, 4'hF, d);
        check(d, expected);
    endtask

    function automatic logic expSel(input logic [4:0] c, input int u);
        case (c)
            SEL_PIN: return capturePin[u];
            SEL_AUDIO_TX: return audioTx;
            SEL_AUDIO_RX: return audioRx;
            default: return (c >= SEL_ETH_CH0 && c <= SEL_ETH_LAST) ? ethEvents[c - 7] : 1'b0;
        endcase
    endfunction

    // Sources are read in the edge's time step before the model's updates land.
    task checkCycles(input int n);
        logic [2:0] e;
        logic [15:0] ha;
        logic [7:0] po, pe;
        repeat (n) begin
            @(posedge sysClk);
            for (int u = 0; u < 3; u++) e[u] = expSel(cfgModel[CAP0_LSB + SEL_W * u +: 5], u);
            ha = cfgModel[16] ? hostAddress : hostAddress << 2;
            po = cfgModel[15] ? hostPinOut : sharedPinOut;
            pe = cfgModel[15] ? hostPinOe : sharedPinOe;
            #1;
            check({13'b0, captureEvent, hostByteAddress}, {13'b0, e, ha});
            check({16'b0, pinOut, pinOe}, {16'b0, po, pe});
            check({15'b0, byteMode, hostEn, lowerBits}, {15'b0, cfgModel[16:0]});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task testReset;
        rd(CFG_ONE_OFFSET, 32'h0000_0000);
        checkCycles(3);
    endtask

    // Each unit gets a different code per pass, so every unit sees all 32 codes.
    task testRouting;
        logic [31:0] d, v;
        logic [4:0] c;
        for (int k = 0; k < 32; k++) begin
            d = 32'h0000_0000;
            v = 32'h0000_0000;
            for (int u = 0; u < 3; u++) begin
                c = 5'(k + 11 * u);
                d[CAP0_LSB + SEL_W * u +: 5] = c;
                v[STAT_VALID_LSB + u] = (c <= 2) || (c >= 7 && c <= 18);
            end
            wr(CFG_ONE_OFFSET, d, 4'hF);
            checkCycles(4);
            rd(CFG_ONE_OFFSET, d);
            access(1'b0, STATUS_OFFSET, 32'h0000_0000, 4'hF, d);
            check(d & 32'hFFFF_FFF8, v);
        end
    endtask

    task testHost;
        for (int m = 0; m < 4; m++) begin
            wr(CFG_ONE_OFFSET, (m << 15) | 32'h0000_5A5A, 4'hF);
            checkCycles(4);
            rd(CFG_ONE_OFFSET, cfgModel);
        end
    endtask

    task testBus;
        wr(CFG_ONE_OFFSET, 32'hFFFF_FFFF, 4'b0011);
        rd(CFG_ONE_OFFSET, cfgModel);
        wr(STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF);
        wr(4'h8, 32'hFFFF_FFFF, 4'hF);
        rd(4'h8, 32'h0000_0000);
        wr(CFG_ONE_OFFSET, 32'hFFFF_FFFF, 4'b1100);
        checkCycles(4);
        rd(CFG_ONE_OFFSET, cfgModel);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("comparisons %0d, mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sysClk);
        nFail++;
        print_verdict;
    end

    initial begin
        repeat (4) @(posedge sysClk);
        reset <= 1'b0;
        testReset;
        testRouting;
        testHost;
        testBus;
        print_verdict;
    end
endmodule // capture_source_host_port_cfg_test

// File: verif/event_source_model.sv
`timescale 1ns/100ps
module event_source_model (
    input wire logic sys_clk,
    input wire logic reset,
    output logic [2:0] capturePin,
    output logic audioTxEvent,
    output logic audioRxEvent,
    output logic [11:0] ethEvents,
    output logic [15:0] hostAddress,
    output logic [7:0] hostPinOut,
    output logic [7:0] hostPinOe,
    output logic [7:0] sharedPinOut,
    output logic [7:0] sharedPinOe
);
    // Every source is redrawn from the pattern each cycle, so a wrong route or a stuck output shows within a few cycles.
    logic [63:0] pattern;
    logic [63:0] shown;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pattern <= 64'h9E37_79B9_7F4A_7C15;
        end else begin
            pattern <= pattern ^ (pattern << 13) ^ (pattern >> 7) ^ (pattern << 17);
        end
    end

    // Sources rest at zero in reset, like the block's own outputs, so that checks reaching
    // back across the release edge compare like with like.
    assign shown = reset ? 64'h0000_0000_0000_0000 : pattern;

    assign capturePin = shown[2:0];
    assign audioTxEvent = shown[3];
    assign audioRxEvent = shown[4];
    assign ethEvents = shown[16:5];
    assign hostAddress = shown[32:17];
    assign hostPinOut = shown[40:33];
    assign hostPinOe = shown[48:41];
    assign sharedPinOut = shown[56:49];
    assign sharedPinOe = shown[63:56] ^ shown[7:0];
endmodule // event_source_model
